// File: inc/abc_pkg.sv
// Package with constants for the block capture engine
package abc_pkg;
  // Clock and timing
  localparam int CLK_HZ          = 25_000_000;
  localparam int SHIFT_DIV_DEF   = 3;
  localparam int TMR_PRESCALE    = 4;
  localparam int TMR_PERIOD_DEF  = 94;
  localparam int TMR_PULSE_TICKS = 2;
  localparam int FRAME_BITS      = 20;
  localparam int FRAME_DELAY     = 1;
  localparam int RESULT_BITS     = 18;
  localparam int BUF_WORDS       = 2048;
  localparam int SCLK_MAX_HZ     = 40_000_000;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_PERIOD  = 8'h08;
  localparam logic [7:0] REG_DIV     = 8'h0C;
  localparam logic [7:0] REG_COUNT   = 8'h10;
  localparam logic [7:0] REG_SCRATCH = 8'h14;
  localparam logic [7:0] REG_LAST    = 8'h18;
  // Control fields
  localparam int CTRL_RUN    = 0;
  localparam int CTRL_CONT   = 1;
  localparam int CTRL_IRQ_EN = 2;
  localparam int CTRL_CLR    = 3;
  // Status fields
  localparam int STAT_DONE    = 0;
  localparam int STAT_RUNNING = 1;
  localparam int STAT_DIVERT  = 2;
  // Reset values
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] PERIOD_RST = 32'h0000_005E;
  localparam logic [31:0] DIV_RST    = 32'h0000_0003;
  // Result mask: clear the two LSBs of the MSB-aligned 20-bit frame
  localparam logic [31:0] RESULT_MASK = 32'hFFFF_C000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {SR_IDLE, SR_WAIT, SR_SHIFT, SR_END} abc_sr_t;
endpackage : abc_pkg

// File: rtl/abc_serial_rx.sv
// Clock-stop serial receiver with generated shift clock
`timescale 1ns/100ps
module abc_serial_rx
  import abc_pkg::*;
#(
  parameter int BITS = FRAME_BITS
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_div,
  input  wire logic        i_frame,
  input  wire logic        i_sdata,
  output logic             o_sclk,
  output logic [31:0]      o_word,
  output logic             o_event
);
  abc_sr_t     state;
  abc_sr_t     next_state;
  logic [8:0]  half_cnt;
  logic [8:0]  next_half_cnt;
  logic        sclk;
  logic        next_sclk;
  logic [4:0]  bit_cnt;
  logic [4:0]  next_bit_cnt;
  logic [31:0] shreg;
  logic [31:0] next_shreg;
  logic [31:0] word;
  logic [31:0] next_word;
  logic        evt;
  logic        next_evt;
  logic        half_tick;
  logic [8:0]  half_lim;

  // One half period of the shift clock is i_div system clocks, or one when i_div is zero
  assign half_lim  = (i_div == 8'h00) ? 9'h001 : {1'b0, i_div};
  assign half_tick = (half_cnt == half_lim - 9'h001);

  always_comb begin
    next_state    = state;
    next_half_cnt = half_cnt;
    next_sclk     = sclk;
    next_bit_cnt  = bit_cnt;
    next_shreg    = shreg;
    next_word     = word;
    next_evt      = 1'b0;
    unique case (state)
      SR_IDLE: begin
        next_sclk     = 1'b0;
        next_half_cnt = 9'h000;
        if (i_frame) begin
          next_state   = SR_WAIT;
          next_bit_cnt = 5'd0;
        end
      end
      // One shift-clock period delay after frame start
      SR_WAIT, SR_SHIFT: begin
        next_half_cnt = half_tick ? 9'h000 : half_cnt + 9'h001;
        if (half_tick) begin
          next_sclk = ~sclk;
          if (sclk) begin
            if (state == SR_WAIT) begin
              next_state = SR_SHIFT;
            end else if (bit_cnt == 5'(BITS)) begin
              next_state = SR_END;
              next_sclk  = 1'b0;
            end
          end else if (state == SR_SHIFT) begin
            next_shreg   = {shreg[30:0], i_sdata};
            next_bit_cnt = bit_cnt + 5'd1;
          end
        end
      end
      SR_END: begin
        next_word  = shreg << (32 - BITS);
        next_evt   = 1'b1;
        next_state = SR_IDLE;
      end
      default: next_state = SR_IDLE;
    endcase
    if (state == SR_SHIFT && bit_cnt == 5'(BITS) && !sclk && half_tick) begin
      next_state = SR_END;
      next_sclk  = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state    <= SR_IDLE;
      half_cnt <= 9'h000;
      sclk     <= 1'b0;
      bit_cnt  <= 5'd0;
      shreg    <= 32'h0000_0000;
      word     <= 32'h0000_0000;
      evt      <= 1'b0;
    end else begin
      state    <= next_state;
      half_cnt <= next_half_cnt;
      sclk     <= next_sclk;
      bit_cnt  <= next_bit_cnt;
      shreg    <= next_shreg;
      word     <= next_word;
      evt      <= next_evt;
    end
  end

  assign o_sclk  = sclk;
  assign o_word  = word;
  assign o_event = evt;
endmodule : abc_serial_rx

// File: rtl/abc_capture.sv
// Block capture top: sample timer, serial receiver, memory writer, regs
`timescale 1ns/100ps
module abc_capture
  import abc_pkg::*;
#(
  parameter int WORDS    = BUF_WORDS,
  parameter int ADDR_W   = 11,
  parameter int PRESCALE = TMR_PRESCALE
) (
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  // AXI4-Lite slave
  input  wire logic [7:0]  I_AWADDR,
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  output logic [1:0]       O_BRESP,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  input  wire logic [7:0]  I_ARADDR,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  // Converter link
  output logic             O_CONVERT_START,
  input  wire logic        I_BUSY,
  output logic             O_CONVERTER_FRAME_INPUT,
  output logic             O_SERIAL_CLOCK_OUT,
  input  wire logic        I_SERIAL_DATA,
  // Sample buffer write port
  output logic             O_MEM_WE,
  output logic [ADDR_W-1:0] O_MEM_ADDR,
  output logic [31:0]      O_MEM_WDATA,
  output logic             O_IRQ
);
  // Control and status state
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic [15:0] timer_period_value;
  logic [15:0] next_timer_period_value;
  logic [7:0]  shift_clock_divider;
  logic [7:0]  next_shift_clock_divider;
  logic        done;
  logic        next_done;
  logic        divert;
  logic        next_divert;
  logic [ADDR_W:0] count;
  logic [ADDR_W:0] next_count;
  logic [31:0] scratch;
  logic [31:0] next_scratch;
  // Timer state
  logic [2:0]  pre_cnt;
  logic [2:0]  next_pre_cnt;
  logic [15:0] tmr_cnt;
  logic [15:0] next_tmr_cnt;
  logic [1:0]  pulse_cnt;
  logic [1:0]  next_pulse_cnt;
  // Bus state
  logic        aw_held;
  logic        next_aw_held;
  logic [7:0]  aw_addr;
  logic [7:0]  next_aw_addr;
  logic        w_held;
  logic        next_w_held;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic [3:0]  w_strb;
  logic [3:0]  next_w_strb;
  logic        bvalid;
  logic        next_bvalid;
  logic [1:0]  bresp;
  logic [1:0]  next_bresp;
  logic        rvalid;
  logic        next_rvalid;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0]  rresp;
  logic [1:0]  next_rresp;
  // Memory port state
  logic        mem_we;
  logic        next_mem_we;
  logic [ADDR_W-1:0] mem_addr;
  logic [ADDR_W-1:0] next_mem_addr;
  logic [31:0] mem_wdata;
  logic [31:0] next_mem_wdata;
  // Receiver
  logic [31:0] rx_word;
  logic        rx_event;
  logic        tick;
  logic        wr_fire;
  logic        running;
  logic [31:0] result;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_PERIOD) ||
             (a == REG_DIV) || (a == REG_COUNT) || (a == REG_SCRATCH);
  endfunction : mapped

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    merge = r;
  endfunction : merge

  // Convert-start directly from the timer, busy frames both ends
  assign O_CONVERTER_FRAME_INPUT = I_BUSY;

  abc_serial_rx #(
    .BITS (FRAME_BITS)
  ) u_rx (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_div   (shift_clock_divider),
    .i_frame (I_BUSY),
    .i_sdata (I_SERIAL_DATA),
    .o_sclk  (O_SERIAL_CLOCK_OUT),
    .o_word  (rx_word),
    .o_event (rx_event)
  );

  assign running = ctrl[CTRL_RUN] && !done;
  assign tick    = (pre_cnt == 3'(PRESCALE - 1));
  assign result  = rx_word & RESULT_MASK;

  // Sample timer
  always_comb begin
    next_pre_cnt   = running ? (tick ? 3'd0 : pre_cnt + 3'd1) : 3'd0;
    next_tmr_cnt   = tmr_cnt;
    next_pulse_cnt = pulse_cnt;
    if (!running) begin
      next_tmr_cnt   = 16'h0000;
      next_pulse_cnt = 2'd0;
    end else if (tick) begin
      if (pulse_cnt != 2'd0) begin
        next_pulse_cnt = pulse_cnt - 2'd1;
      end
      if (tmr_cnt >= timer_period_value - 16'h0001) begin
        next_tmr_cnt   = 16'h0000;
        next_pulse_cnt = 2'(TMR_PULSE_TICKS);
      end else begin
        next_tmr_cnt = tmr_cnt + 16'h0001;
      end
    end
  end

  // Inverted pulse: low for two timer ticks
  assign O_CONVERT_START = (pulse_cnt == 2'd0);

  // Transfer engine and registers
  assign wr_fire = aw_held && w_held && !bvalid;
  always_comb begin
    next_ctrl                = ctrl;
    next_timer_period_value  = timer_period_value;
    next_shift_clock_divider = shift_clock_divider;
    next_done                = done;
    next_divert              = divert;
    next_count               = count;
    next_scratch             = scratch;
    next_mem_we              = 1'b0;
    next_mem_addr            = mem_addr;
    next_mem_wdata           = mem_wdata;
    next_ctrl[CTRL_CLR]      = 1'b0;
    if (rx_event && ctrl[CTRL_RUN]) begin
      if (divert) begin
        next_scratch = result;
      end else begin
        next_mem_we    = 1'b1;
        next_mem_addr  = count[ADDR_W-1:0];
        next_mem_wdata = result;
        if (count == (ADDR_W+1)'(WORDS - 1)) begin
          next_done = 1'b1;
          if (ctrl[CTRL_CONT]) begin
            next_count = '0;
            next_done  = 1'b0;
          end else begin
            next_count  = count + 1'b1;
            next_divert = 1'b1;
          end
        end else begin
          next_count = count + 1'b1;
        end
      end
    end
    if (wr_fire) begin
      unique case (aw_addr)
        REG_CTRL:   next_ctrl = merge(ctrl, w_data, w_strb);
        REG_PERIOD: next_timer_period_value =
                      16'(merge({16'h0000, timer_period_value}, w_data, w_strb));
        REG_DIV:    next_shift_clock_divider =
                      8'(merge({24'h0, shift_clock_divider}, w_data, w_strb));
        default:    next_ctrl = next_ctrl;
      endcase
      if (aw_addr == REG_CTRL && w_strb[0] && w_data[CTRL_CLR]) begin
        next_done   = next_done && !done;
        next_divert = next_divert && !divert;
        if (!next_done) begin
          next_count = '0;
        end
      end
    end
  end

  // AXI4-Lite channels
  assign O_AWREADY = !aw_held;
  assign O_WREADY  = !w_held;
  assign O_ARREADY = !rvalid;
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (I_AWVALID && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = I_AWADDR;
    end
    if (I_WVALID && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = I_WDATA;
      next_w_strb = I_WSTRB;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (mapped(aw_addr) && aw_addr != REG_STATUS &&
                      aw_addr != REG_COUNT && aw_addr != REG_SCRATCH)
                     ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid && I_BREADY) begin
      next_bvalid = 1'b0;
    end
    if (I_ARVALID && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp  = mapped(I_ARADDR) ? RESP_OKAY : RESP_SLVERR;
      unique case (I_ARADDR)
        REG_CTRL:    next_rdata = ctrl;
        REG_STATUS:  next_rdata = {29'h0, divert, running, done};
        REG_PERIOD:  next_rdata = {16'h0000, timer_period_value};
        REG_DIV:     next_rdata = {24'h0, shift_clock_divider};
        REG_COUNT:   next_rdata = 32'(count);
        REG_SCRATCH: next_rdata = scratch;
        default:     next_rdata = 32'h0000_0000;
      endcase
    end else if (rvalid && I_RREADY) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      ctrl                <= CTRL_RST;
      timer_period_value  <= PERIOD_RST[15:0];
      shift_clock_divider <= DIV_RST[7:0];
      done                <= 1'b0;
      divert              <= 1'b0;
      count               <= '0;
      scratch             <= 32'h0000_0000;
      pre_cnt             <= 3'd0;
      tmr_cnt             <= 16'h0000;
      pulse_cnt           <= 2'd0;
      aw_held             <= 1'b0;
      aw_addr             <= 8'h00;
      w_held              <= 1'b0;
      w_data              <= 32'h0000_0000;
      w_strb              <= 4'h0;
      bvalid              <= 1'b0;
      bresp               <= RESP_OKAY;
      rvalid              <= 1'b0;
      rdata               <= 32'h0000_0000;
      rresp               <= RESP_OKAY;
      mem_we              <= 1'b0;
      mem_addr            <= '0;
      mem_wdata           <= 32'h0000_0000;
    end else begin
      ctrl                <= next_ctrl;
      timer_period_value  <= next_timer_period_value;
      shift_clock_divider <= next_shift_clock_divider;
      done                <= next_done;
      divert              <= next_divert;
      count               <= next_count;
      scratch             <= next_scratch;
      pre_cnt             <= next_pre_cnt;
      tmr_cnt             <= next_tmr_cnt;
      pulse_cnt           <= next_pulse_cnt;
      aw_held             <= next_aw_held;
      aw_addr             <= next_aw_addr;
      w_held              <= next_w_held;
      w_data              <= next_w_data;
      w_strb              <= next_w_strb;
      bvalid              <= next_bvalid;
      bresp               <= next_bresp;
      rvalid              <= next_rvalid;
      rdata               <= next_rdata;
      rresp               <= next_rresp;
      mem_we              <= next_mem_we;
      mem_addr            <= next_mem_addr;
      mem_wdata           <= next_mem_wdata;
    end
  end

  assign O_BVALID    = bvalid;
  assign O_BRESP     = bresp;
  assign O_RVALID    = rvalid;
  assign O_RDATA     = rdata;
  assign O_RRESP     = rresp;
  assign O_MEM_WE    = mem_we;
  assign O_MEM_ADDR  = mem_addr;
  assign O_MEM_WDATA = mem_wdata;
  assign O_IRQ       = done && ctrl[CTRL_IRQ_EN];
endmodule : abc_capture

// File: tb/abc_capture_chk.sv
// Assertion checker bound to the block capture top
`timescale 1ns/100ps
module abc_capture_chk
  import abc_pkg::*;
#(
  parameter int WORDS    = BUF_WORDS,
  parameter int ADDR_W   = 11,
  parameter int PRESCALE = TMR_PRESCALE
) (
  input wire logic              I_CLK,
  input wire logic              I_RST_N,
  input wire logic              I_ARVALID,
  input wire logic              O_ARREADY,
  input wire logic              O_RVALID,
  input wire logic              I_RREADY,
  input wire logic              O_BVALID,
  input wire logic              I_BREADY,
  input wire logic              O_CONVERT_START,
  input wire logic              I_BUSY,
  input wire logic              O_CONVERTER_FRAME_INPUT,
  input wire logic              O_SERIAL_CLOCK_OUT,
  input wire logic              O_MEM_WE,
  input wire logic [ADDR_W-1:0] O_MEM_ADDR,
  input wire logic [31:0]       O_MEM_WDATA,
  input wire logic              O_IRQ
);
  logic [7:0]        low_cnt;
  logic [5:0]        rise_cnt;
  logic [ADDR_W-1:0] wr_next;
  logic [8:0]        ph_cnt;
  logic [8:0]        hi_len;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  // Low time, shift edges per frame, next address, shift phase lengths
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      low_cnt  <= '0;
      rise_cnt <= '0;
      wr_next  <= '0;
      ph_cnt   <= '0;
      hi_len   <= '0;
    end else begin
      ph_cnt <= $changed(O_SERIAL_CLOCK_OUT) ? 9'h001 : ph_cnt + 9'h001;
      if ($fell(O_SERIAL_CLOCK_OUT)) hi_len <= ph_cnt;
      low_cnt <= O_CONVERT_START ? 8'h00 : low_cnt + 8'h01;
      if ($rose(I_BUSY)) rise_cnt <= '0;
      else if ($rose(O_SERIAL_CLOCK_OUT)) rise_cnt <= rise_cnt + 6'h01;
      if (O_MEM_WE) wr_next <= O_MEM_ADDR + 1'b1;
    end
  end
  pulse_width_a: assert property (
    $rose(O_CONVERT_START) |-> low_cnt == 8'(2 * PRESCALE))
    else $error("convert-start pulse width wrong");
  frame_pass_a: assert property (
    O_CONVERTER_FRAME_INPUT == I_BUSY)
    else $error("frame input not following busy");
  sclk_rate_a: assert property (
    $rose(O_SERIAL_CLOCK_OUT) && rise_cnt != 6'd0 |-> ph_cnt == hi_len)
    else $error("shift clock halves unequal");
  // One delay period pulse precedes the data clocks
  frame_len_a: assert property (
    O_MEM_WE |-> rise_cnt == 6'(FRAME_BITS + FRAME_DELAY))
    else $error("stored word after wrong count of shift edges");
  one_event_a: assert property (
    O_MEM_WE |=> !O_MEM_WE)
    else $error("more than one store per frame");
  low_bits_a: assert property (
    O_MEM_WE |-> (O_MEM_WDATA & ~RESULT_MASK) == 32'h0000_0000)
    else $error("stored word has bits below the result");
  addr_step_a: assert property (
    O_MEM_WE |-> O_MEM_ADDR == wr_next || O_MEM_ADDR == '0)
    else $error("store address did not step by one");
  halt_a: assert property (
    O_IRQ |-> O_CONVERT_START)
    else $error("conversion started after completion");
  rd_lat_a: assert property (
    I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read data late");
  rd_done_a: assert property (
    O_RVALID && I_RREADY |=> !O_RVALID)
    else $error("read data held after handshake");
  wr_done_a: assert property (
    O_BVALID && I_BREADY |=> !O_BVALID)
    else $error("write response held after handshake");
endmodule : abc_capture_chk

bind abc_capture abc_capture_chk #(
  .WORDS(WORDS), .ADDR_W(ADDR_W), .PRESCALE(PRESCALE)
) u_abc_capture_chk (
  .I_CLK, .I_RST_N, .I_ARVALID, .O_ARREADY, .O_RVALID, .I_RREADY,
  .O_BVALID, .I_BREADY, .O_CONVERT_START, .I_BUSY,
  .O_CONVERTER_FRAME_INPUT, .O_SERIAL_CLOCK_OUT, .O_MEM_WE,
  .O_MEM_ADDR, .O_MEM_WDATA, .O_IRQ
);

// File: tb/abc_adc_model.sv
// Behavioural serial converter on the far side of the link
`timescale 1ns/100ps
module abc_adc_model (
  input  wire logic  i_clk,
  input  wire logic  i_convert_start,
  input  wire logic  i_sclk,
  input  wire logic  i_extra,
  output logic       o_busy = 1'b0,
  output logic       o_sdata = 1'b0,
  output logic       o_frame_go = 1'b0,
  output logic [19:0] o_frame = 20'h0_0000
);
  logic [19:0] sh;
  logic        cs_q = 1'b1;
  logic        sclk_q;
  int          falls;
  always begin
    @(posedge i_clk);
    // Convert-start fall, or a stray frame on command
    if ((cs_q && !i_convert_start) || i_extra) begin
      repeat (2 + $urandom_range(3)) @(posedge i_clk);
      sh = 20'($urandom);
      o_frame <= sh;
      o_frame_go <= 1'b1;
      o_busy <= 1'b1;
      o_sdata <= sh[19];
      @(posedge i_clk);
      o_frame_go <= 1'b0;
      @(posedge i_clk);
      o_busy <= 1'b0;
      falls = 0;
      sclk_q = 1'b0;
      // Settled clock; the delay period's fall shifts nothing
      while (falls < 21) begin
        @(negedge i_clk);
        if (sclk_q && !i_sclk) begin
          falls++;
          if (falls > 1) begin
            sh = sh << 1;
            // Released line shows the inverse of the last bit
            o_sdata <= (falls < 21) ? sh[19] : ~o_sdata;
          end
        end
        sclk_q = i_sclk;
      end
    end
    cs_q = i_convert_start;
  end
endmodule : abc_adc_model

// File: tb/tb_abc_capture.sv
// Self-checking bench for the block capture top
`timescale 1ns/100ps
module tb_abc_capture import abc_pkg::*;;
  localparam int WORDS = 8;
  localparam int PER   = 50;
  logic        I_CLK = 1'b0, I_RST_N = 1'b0, extra = 1'b0, cont = 1'b0;
  logic [7:0]  I_AWADDR = '0, I_ARADDR = '0;
  logic [31:0] I_WDATA = '0, O_RDATA, O_MEM_WDATA, scr_exp;
  logic [3:0]  I_WSTRB = '0;
  logic        I_AWVALID = 0, I_WVALID = 0, I_BREADY = 0;
  logic        I_ARVALID = 0, I_RREADY = 0, I_BUSY, I_SERIAL_DATA;
  logic        O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
  logic        O_IRQ, O_CONVERT_START, O_CONVERTER_FRAME_INPUT;
  logic        O_SERIAL_CLOCK_OUT, O_MEM_WE, frame_go;
  logic [1:0]  O_BRESP, O_RRESP;
  logic [10:0] O_MEM_ADDR;
  logic [19:0] frame;
  logic [42:0] mem_q[$];
  logic [33:0] rd_q[$];
  logic [1:0]  b_q[$];
  int          error_cnt = 0, checked = 0, k = 0, cyc = 0, last_fall = -1;
  abc_capture #(.WORDS(WORDS)) u_abc_capture (
    .I_CLK, .I_RST_N, .I_AWADDR, .I_AWVALID, .O_AWREADY, .I_WDATA,
    .I_WSTRB, .I_WVALID, .O_WREADY, .O_BRESP, .O_BVALID, .I_BREADY,
    .I_ARADDR, .I_ARVALID, .O_ARREADY, .O_RDATA, .O_RRESP, .O_RVALID,
    .I_RREADY, .O_CONVERT_START, .I_BUSY, .O_CONVERTER_FRAME_INPUT,
    .O_SERIAL_CLOCK_OUT, .I_SERIAL_DATA, .O_MEM_WE, .O_MEM_ADDR,
    .O_MEM_WDATA, .O_IRQ);
  abc_adc_model u_abc_adc_model (.i_clk(I_CLK), .i_extra(extra),
    .i_convert_start(O_CONVERT_START), .i_sclk(O_SERIAL_CLOCK_OUT),
    .o_busy(I_BUSY), .o_sdata(I_SERIAL_DATA), .o_frame_go(frame_go),
    .o_frame(frame));
  initial forever #20 I_CLK = ~I_CLK;
  task automatic chk(input string what, input logic [63:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic complete_run;
    if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] r);
    @(posedge I_CLK);
    b_q.push_back(r);
    I_AWADDR <= a;
    I_WDATA <= d;
    I_WSTRB <= s;
    I_AWVALID <= 1'b1;
    I_WVALID <= 1'b1;
    I_BREADY <= 1'b1;
    do begin
      @(posedge I_CLK);
      if (I_AWVALID && O_AWREADY) I_AWVALID <= 1'b0;
      if (I_WVALID && O_WREADY) I_WVALID <= 1'b0;
    end while (!(O_BVALID === 1'b1 && I_BREADY));
    I_BREADY <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    @(posedge I_CLK);
    rd_q.push_back({r, d});
    I_ARADDR <= a;
    I_ARVALID <= 1'b1;
    I_RREADY <= 1'b1;
    do begin
      @(posedge I_CLK);
      if (I_ARVALID && O_ARREADY) I_ARVALID <= 1'b0;
    end while (!(O_RVALID === 1'b1 && I_RREADY));
    I_RREADY <= 1'b0;
  endtask : axi_rd
  // Notes expected stores per frame, compares every result seen
  always @(posedge I_CLK) begin
    cyc++;
    if (O_RVALID && I_RREADY) chk("rdata", {O_RRESP, O_RDATA}, rd_q.pop_front());
    if (O_BVALID && I_BREADY) chk("bresp", O_BRESP, b_q.pop_front());
    if (I_RST_N && O_MEM_WE !== 1'b0) begin
      if (mem_q.size() == 0) chk("stray store", 1'b1, 1'b0);
      else chk("store", {O_MEM_ADDR, O_MEM_WDATA}, mem_q.pop_front());
    end
    if (frame_go) begin
      if (cont || k < WORDS)
        mem_q.push_back({11'(k % WORDS), {frame, 12'h000} & RESULT_MASK});
      else scr_exp = {frame, 12'h000} & RESULT_MASK;
      k++;
    end
    if ($fell(O_CONVERT_START)) begin
      if (last_fall >= 0) chk("period", cyc - last_fall, PER * TMR_PRESCALE);
      last_fall = cyc;
    end
  end
  initial begin
    repeat (20000) @(posedge I_CLK);
    error_cnt++;
    complete_run;
  end
  initial begin
    void'($urandom(11));
    repeat (4) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    axi_rd(REG_CTRL, CTRL_RST, RESP_OKAY);
    axi_rd(REG_PERIOD, PERIOD_RST, RESP_OKAY);
    axi_rd(REG_DIV, DIV_RST, RESP_OKAY);
    axi_rd(8'h1C, 32'h0000_0000, RESP_SLVERR);
    axi_wr(REG_STATUS, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
    axi_rd(REG_STATUS, 32'h0000_0000, RESP_OKAY);
    axi_wr(REG_PERIOD, 32'h0000_AB32, 4'h1, RESP_OKAY);
    axi_rd(REG_PERIOD, 32'h0000_0032, RESP_OKAY);
    // Block capture: run with interrupt enabled
    axi_wr(REG_CTRL, 32'h0000_0005, 4'hF, RESP_OKAY);
    while (O_IRQ !== 1'b1) @(posedge I_CLK);
    @(posedge I_CLK);
    chk("pending", mem_q.size(), 0);
    repeat (3 * PER * TMR_PRESCALE) @(posedge I_CLK);
    chk("frames", k, WORDS);
    @(posedge I_CLK);
    extra <= 1'b1;
    @(posedge I_CLK);
    extra <= 1'b0;
    repeat (200) @(posedge I_CLK);
    axi_rd(REG_SCRATCH, scr_exp, RESP_OKAY);
    axi_rd(REG_STATUS, 32'h0000_0005, RESP_OKAY);
    axi_wr(REG_CTRL, 32'h0000_0008, 4'hF, RESP_OKAY);
    @(posedge I_CLK);
    chk("irq clear", O_IRQ, 1'b0);
    // Continuous capture at the fastest shift clock
    k = 0;
    cont = 1'b1;
    last_fall = -1;
    axi_wr(REG_DIV, 32'h0000_0001, 4'hF, RESP_OKAY);
    axi_wr(REG_CTRL, 32'h0000_0007, 4'hF, RESP_OKAY);
    while (k < WORDS + 3 || mem_q.size() != 0) @(posedge I_CLK);
    chk("cont irq", O_IRQ, 1'b0);
    axi_wr(REG_CTRL, 32'h0000_0000, 4'hF, RESP_OKAY);
    repeat (2 * PER * TMR_PRESCALE) @(posedge I_CLK);
    chk("stopped", k, WORDS + 3);
    complete_run;
  end
endmodule : tb_abc_capture
